// file: logic/drive_command_source_and_sleep_control.sv
// command source, speed mode, display scaling and sleep control top
//
// Overview of operation
// - key-only-in-local policy honours auto/manual key only in local.
// - auto policy takes speed from select-input chosen reference, ignores key.
// - no select input gives an automatic reference: keypad speed control.
// - manual policy uses keypad up/down only, auto/manual key ignored.
// - key-always-active policy honours auto/manual key in every location.
// - local to remote forces auto; remote to local forces manual.
// - local source takes start only from keypad, location key ignored.
// - remote source takes start only from strip, location key ignored.
// - serial source takes start only from serial link.
// - keypad toggle switches location only if enter follows within 3 s.
// - keypad toggle in local refuses start unless terminal stop closed.
// - strip-selected mode is local while location select input closed.
// - keypad toggle without stop ignores terminal stop while local.
// - keypad stop always stops; terminal stop except no-stop mode local.
// - pid unit with manual speed or pid disabled shows hertz.
// - frequency scale applies only for the scaled unit group.
// - scaled load at 150 percent trips overload after one minute.
// - speed below idle level for idle delay enters sleep, zero speed.
// - sleep ends when commanded speed reaches idle level plus 2 Hz or run stops.
// - sleep shown in display status while sleep is active.
// - idle timer counts below level, resets at or above level.
// - start while stopped below idle level sleeps at once.
// - idle delay sets how long below level before sleep.
// - location select input picks local only in strip-selected mode.
module drive_command_source_and_sleep_control
  import drive_mode_pkg::*;
#(
  parameter longint unsigned CONFIRM_CYCLES = CONFIRM_CYC,
  parameter longint unsigned OL_CYCLES      = OL_TRIP_CYC
)(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // keypad keys and terminal contacts, raw
  input  wire contacts_t            contacts_raw,
  // serial link commands, same clock
  input  wire logic                 serial_start,
  input  wire logic                 serial_stop,
  // configuration
  input  wire speed_source_policy_t speed_source_policy,
  input  wire cmd_source_t          cmd_source,
  input  wire select_cfg_t          select_cfg,
  input  wire unit_class_t          unit_class,
  input  wire logic                 pid_enabled,
  input  wire logic [15:0]          frequency_display_scale,
  input  wire logic [15:0]          load_display_scale,
  input  wire logic [15:0]          idle_entry_level,
  input  wire logic [15:0]          idle_entry_delay,
  // measured and commanded values
  input  wire logic [15:0]          output_frequency,
  input  wire logic [15:0]          drive_load,
  input  wire logic [15:0]          commanded_speed,
  // status outputs
  output logic                      is_local,
  output logic                      auto_speed,
  output speed_ref_t                speed_ref,
  output logic                      run,
  output logic                      motor_zero_speed,
  output logic                      sleep_shown,
  output logic                      display_hertz,
  output logic [31:0]               speed_display,
  output logic [15:0]               load_display,
  output logic                      overload_trip
);

  // ------
  // input conditioning
  // ------
  contacts_t c;
  contacts_t c_prev;
  logic      sleeping;

  contact_debounce u_debounce (
    .clk   (clk),
    .rst   (rst),
    .raw   (contacts_raw),
    .clean (c)
  );

  // previous filtered state for press edges
  always_ff @(posedge clk) begin
    if (rst) c_prev <= '0;
    else     c_prev <= c;
  end

  logic press_am;
  logic press_lr;
  logic press_enter;
  logic press_start;
  logic press_stop;
  logic strip_start_edge;

  assign press_am         = c.key_speed_source_policy & ~c_prev.key_speed_source_policy;
  assign press_lr         = c.key_loc_rem  & ~c_prev.key_loc_rem;
  assign press_enter      = c.key_enter    & ~c_prev.key_enter;
  assign press_start      = c.key_start    & ~c_prev.key_start;
  assign press_stop       = c.key_stop;
  assign strip_start_edge = c.terminal_start & ~c_prev.terminal_start;

  // ------
  // location selection
  // ------
  logic        toggle_mode;
  logic        pending;
  logic [39:0] confirm_cnt;
  logic        strip_local;
  logic        next_local;

  assign toggle_mode = (cmd_source == cmd_keypad) ||
                       (cmd_source == cmd_keypad_nostop);

  // closed location select input on a or c
  assign strip_local =
    (select_cfg.a == location_select_function && c.select_input_a) ||
    (select_cfg.c == location_select_function && c.select_input_c);

  // pending toggle window after the location key
  always_ff @(posedge clk) begin
    if (rst || !toggle_mode) begin
      pending     <= 1'b0;
      confirm_cnt <= '0;
    end else if (press_lr) begin
      pending     <= 1'b1;
      confirm_cnt <= '0;
    end else if (pending && press_enter) begin
      pending     <= 1'b0;
    end else if (pending && confirm_cnt == 40'(CONFIRM_CYCLES - 1)) begin
      pending     <= 1'b0;
    end else if (pending) begin
      confirm_cnt <= confirm_cnt + 40'h1;
    end
  end

  // next location from command source
  always_comb begin
    next_local = is_local;
    case (cmd_source)
      cmd_local:               next_local = 1'b1;
      cmd_remote:              next_local = 1'b0;
      cmd_serial:              next_local = 1'b0;
      strip_selected_location: next_local = strip_local;
      cmd_keypad,
      cmd_keypad_nostop: begin
        if (pending && press_enter) next_local = ~is_local;
      end
      default:                 next_local = is_local;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) is_local <= 1'b1;
    else     is_local <= next_local;
  end

  // ------
  // auto / manual speed control
  // ------
  logic key_enabled;
  logic any_auto;
  logic next_auto;

  assign any_auto = is_auto_fn(select_cfg.a) || is_auto_fn(select_cfg.b) ||
                    is_auto_fn(select_cfg.c);

  always_comb begin
    case (speed_source_policy)
      key_only_in_local: key_enabled = next_local;
      key_always_active: key_enabled = 1'b1;
      default:           key_enabled = 1'b0;
    endcase
  end

  // location change forces mode, then the key may flip it
  always_comb begin
    next_auto = auto_speed;
    if (next_local && !is_local)      next_auto = 1'b0;
    else if (!next_local && is_local) next_auto = 1'b1;
    if (key_enabled && press_am)      next_auto = ~next_auto;
  end

  always_ff @(posedge clk) begin
    if (rst) auto_speed <= 1'b0;
    else     auto_speed <= next_auto;
  end

  // effective reference source
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_ref <= ref_keypad;
    end else if (speed_source_policy == policy_manual) begin
      speed_ref <= ref_keypad;
    end else if (speed_source_policy != policy_auto && !auto_speed) begin
      speed_ref <= ref_keypad;
    end else if (!any_auto) begin
      speed_ref <= ref_keypad;
    end else if (is_auto_fn(select_cfg.a) && c.select_input_a) begin
      speed_ref <= fn_to_ref(select_cfg.a);
    end else if (is_auto_fn(select_cfg.b) && c.select_input_b) begin
      speed_ref <= fn_to_ref(select_cfg.b);
    end else if (is_auto_fn(select_cfg.c) && c.select_input_c) begin
      speed_ref <= fn_to_ref(select_cfg.c);
    end else begin
      speed_ref <= ref_keypad;
    end
  end

  // ------
  // start / stop
  // ------
  logic term_stop_active;
  logic stop_cmd;
  logic start_cmd;
  logic start_allowed;

  assign term_stop_active = !(cmd_source == cmd_keypad_nostop && is_local);

  // open terminal stop contact means stop
  assign stop_cmd =
    press_stop ||
    (term_stop_active && !c.terminal_stop_input) ||
    (cmd_source == cmd_serial && serial_stop);

  always_comb begin
    case (cmd_source)
      cmd_serial: start_cmd = serial_start;
      default:    start_cmd = is_local ? press_start : strip_start_edge;
    endcase
  end

  // keypad toggle local needs closed stop contact
  assign start_allowed =
    !(cmd_source == cmd_keypad && is_local && !c.terminal_stop_input);

  logic start_req;
  assign start_req = start_cmd && start_allowed && !stop_cmd && !run;

  always_ff @(posedge clk) begin
    if (rst)            run <= 1'b0;
    else if (stop_cmd)  run <= 1'b0;
    else if (start_req) run <= 1'b1;
  end

  // ------
  // sleep
  // ------
  idle_supervisor u_idle (
    .clk              (clk),
    .rst              (rst),
    .running          (run),
    .start_req        (start_req),
    .commanded_speed  (commanded_speed),
    .idle_entry_level (idle_entry_level),
    .idle_entry_delay (idle_entry_delay),
    .sleeping         (sleeping)
  );

  // zero speed and status indication
  always_ff @(posedge clk) begin
    if (rst) begin
      motor_zero_speed <= 1'b1;
      sleep_shown      <= 1'b0;
    end else begin
      motor_zero_speed <= !run || sleeping;
      sleep_shown      <= sleeping;
    end
  end

  // ------
  // display scaling and overload
  // ------
  logic [31:0] load_prod;
  logic [15:0] load_scaled;
  logic [39:0] ol_cnt;

  assign load_prod   = (32'(drive_load) * 32'(load_display_scale)) /
                       32'(PCT_FULL);
  assign load_scaled = (load_prod > 32'h0000_ffff) ? 16'hffff
                                                   : load_prod[15:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      display_hertz <= 1'b1;
      speed_display <= '0;
      load_display  <= '0;
    end else begin
      display_hertz <= (unit_class == unit_hertz) ||
        (unit_class == unit_pid && (!auto_speed || !pid_enabled));
      if (unit_class == unit_scaled)
        speed_display <= 32'(output_frequency) *
                         32'(frequency_display_scale);
      else
        speed_display <= 32'(output_frequency);
      load_display  <= load_scaled;
    end
  end

  // one minute at or above trip load
  always_ff @(posedge clk) begin
    if (rst || load_scaled < OL_TRIP_PCT) begin
      ol_cnt        <= '0;
      overload_trip <= 1'b0;
    end else if (ol_cnt == 40'(OL_CYCLES - 1)) begin
      overload_trip <= 1'b1;
    end else begin
      ol_cnt <= ol_cnt + 40'h1;
    end
  end

endmodule

// file: logic/drive_mode_pkg.sv
// shared constants, encodings and carrier structs for the drive mode block
package drive_mode_pkg;

  // ------
  // timing
  // ------
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned CONFIRM_WIN_S   = 3;
  localparam longint unsigned CONFIRM_CYC =
    longint'(CONFIRM_WIN_S) * longint'(CLK_HZ);
  localparam int unsigned DEBOUNCE_US     = 10;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OL_TRIP_S       = 60;
  localparam longint unsigned OL_TRIP_CYC =
    longint'(OL_TRIP_S) * longint'(CLK_HZ);
  localparam int unsigned SEC_CYC         = CLK_HZ;

  // ------
  // numeric thresholds (speed in 0.1 Hz, load in %)
  // ------
  localparam logic [15:0] WAKE_MARGIN     = 16'h0014; // 2 Hz hysteresis
  localparam logic [15:0] OL_TRIP_PCT     = 16'h0096; // 150 %
  localparam logic [15:0] PCT_FULL        = 16'h0064; // 100 %

  // ------
  // encodings
  // ------
  typedef enum logic [1:0] {
    key_only_in_local = 2'h0,
    policy_auto       = 2'h1,
    policy_manual     = 2'h2,
    key_always_active = 2'h3
  } speed_source_policy_t;

  typedef enum logic [2:0] {
    cmd_local               = 3'h0,
    cmd_remote              = 3'h1,
    cmd_serial              = 3'h2,
    cmd_keypad              = 3'h3,
    strip_selected_location = 3'h4,
    cmd_keypad_nostop       = 3'h5
  } cmd_source_t;

  typedef enum logic [2:0] {
    fn_none                  = 3'h0,
    fn_volt_ref              = 3'h1,
    fn_current_ref           = 3'h2,
    fn_preset                = 3'h3,
    location_select_function = 3'h4,
    fn_other                 = 3'h5
  } select_fn_t;

  typedef enum logic [1:0] {
    ref_keypad  = 2'h0,
    ref_volt    = 2'h1,
    ref_current = 2'h2,
    ref_preset  = 2'h3
  } speed_ref_t;

  typedef enum logic [1:0] {
    unit_hertz  = 2'h0,
    unit_scaled = 2'h1,
    unit_other  = 2'h2,
    unit_pid    = 2'h3
  } unit_class_t;

  // debounced contact and key bundle
  typedef struct packed {
    logic key_speed_source_policy;
    logic key_loc_rem;
    logic key_enter;
    logic key_start;
    logic key_stop;
    logic terminal_stop_input;
    logic terminal_start;
    logic select_input_a;
    logic select_input_b;
    logic select_input_c;
  } contacts_t;

  localparam int unsigned N_CONTACTS = $bits(contacts_t);

  // three select input function assignments
  typedef struct packed {
    select_fn_t a;
    select_fn_t b;
    select_fn_t c;
  } select_cfg_t;

  // returns true when a select function supplies an automatic reference
  function automatic logic is_auto_fn(select_fn_t f);
    return (f == fn_volt_ref) || (f == fn_current_ref) || (f == fn_preset);
  endfunction

  // maps a select function to a reference source
  function automatic speed_ref_t fn_to_ref(select_fn_t f);
    case (f)
      fn_volt_ref:    return ref_volt;
      fn_current_ref: return ref_current;
      fn_preset:      return ref_preset;
      default:        return ref_keypad;
    endcase
  endfunction

endpackage

// file: logic/contact_debounce.sv
// synchroniser and debounce filter for a bank of contacts
module contact_debounce
  import drive_mode_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // raw and filtered contacts
  input  wire logic [N_CONTACTS-1:0] raw,
  output logic      [N_CONTACTS-1:0] clean
);

  localparam logic [15:0] DB_LAST = 16'(DEBOUNCE_CYC - 1);

  logic [N_CONTACTS-1:0] sync_a;
  logic [N_CONTACTS-1:0] sync_b;
  logic [15:0]           cnt [N_CONTACTS];

  // two flop synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // per contact stability counter
  always_ff @(posedge clk) begin
    for (int i = 0; i < N_CONTACTS; i++) begin
      if (rst) begin
        cnt[i]   <= '0;
        clean[i] <= 1'b0;
      end else if (sync_b[i] == clean[i]) begin
        cnt[i] <= '0;
      end else if (cnt[i] == DB_LAST) begin
        cnt[i]   <= '0;
        clean[i] <= sync_b[i];
      end else begin
        cnt[i] <= cnt[i] + 16'h0001;
      end
    end
  end

endmodule

// file: logic/idle_supervisor.sv
// sleep supervisor with delay timer and wake hysteresis
module idle_supervisor
  import drive_mode_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // run state and settings
  input  wire logic        running,
  input  wire logic        start_req,
  input  wire logic [15:0] commanded_speed,
  input  wire logic [15:0] idle_entry_level,
  input  wire logic [15:0] idle_entry_delay,
  // status
  output logic             sleeping
);

  logic [31:0] sec_cnt;
  logic [15:0] delay_cnt;
  logic        below;
  logic        wake_ok;

  assign below   = commanded_speed < idle_entry_level;
  assign wake_ok = {1'b0, commanded_speed} >=
                   ({1'b0, idle_entry_level} + {1'b0, WAKE_MARGIN});

  // delay timer in whole seconds, cleared on return to level
  always_ff @(posedge clk) begin
    if (rst || !below || sleeping || !running) begin
      sec_cnt   <= '0;
      delay_cnt <= '0;
    end else if (sec_cnt == 32'(SEC_CYC - 1)) begin
      sec_cnt   <= '0;
      delay_cnt <= delay_cnt + 16'h0001;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
    end
  end

  // sleep entry and wake
  always_ff @(posedge clk) begin
    if (rst) begin
      sleeping <= 1'b0;
    end else if (sleeping) begin
      if (wake_ok || !running) sleeping <= 1'b0;
    end else if (start_req && below) begin
      sleeping <= 1'b1;
    end else if (running && below && delay_cnt >= idle_entry_delay) begin
      sleeping <= 1'b1;
    end
  end

endmodule

// file: testbench/drive_mode_monitor.sv
// port assertions for the drive mode block
module drive_mode_monitor
  import drive_mode_pkg::*;
#(
  parameter longint unsigned CONFIRM_CYCLES = 200,
  parameter longint unsigned OL_CYCLES      = 300
)(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // watched inputs
  input wire contacts_t   contacts_raw,
  input wire logic        serial_stop,
  input wire cmd_source_t cmd_source,
  input wire unit_class_t unit_class,
  input wire logic        pid_enabled,
  input wire logic [15:0] frequency_display_scale,
  input wire logic [15:0] idle_entry_level,
  input wire logic [15:0] output_frequency,
  input wire logic [15:0] commanded_speed,
  // watched outputs
  input wire logic        is_local,
  input wire logic        run,
  input wire logic        motor_zero_speed,
  input wire logic        sleep_shown,
  input wire logic        display_hertz,
  input wire logic [31:0] speed_display,
  input wire logic [15:0] load_display,
  input wire logic        overload_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // helper counters
  // ------
  localparam logic [15:0] OL_LATE = 16'(OL_CYCLES + 64'd4);
  logic [11:0] stop_cnt;
  logic [15:0] ol_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles the raw stop key has been held
  always_ff @(posedge clk) begin
    if (rst || !contacts_raw.key_stop) stop_cnt <= 12'h000;
    else if (stop_cnt != 12'hfff) stop_cnt <= stop_cnt + 12'h001;
  end
  // cycles the scaled load has sat at or above the trip level
  always_ff @(posedge clk) begin
    if (rst || load_display < OL_TRIP_PCT) ol_cnt <= 16'h0000;
    else if (ol_cnt != 16'hffff) ol_cnt <= ol_cnt + 16'h0001;
  end
  // ------
  // assertions
  // ------
  AST_KEY_STOP: assert property (stop_cnt == 12'ha28 |-> !run)
    else $error("stop key ignored");
  AST_SERIAL_STOP: assert property (
    cmd_source == cmd_serial && serial_stop |=> !run)
    else $error("serial stop ignored");
  AST_SCALED: assert property (unit_class == unit_scaled |=>
    speed_display == 32'($past(output_frequency)) *
                     32'($past(frequency_display_scale)))
    else $error("scaled display");
  AST_PLAIN: assert property (unit_class != unit_scaled |=>
    speed_display == 32'($past(output_frequency)))
    else $error("plain display");
  AST_PID_HERTZ: assert property (
    unit_class == unit_pid && !pid_enabled |=> display_hertz)
    else $error("pid unit not hertz");
  AST_OL_TRIP: assert property (ol_cnt == OL_LATE |-> overload_trip)
    else $error("no trip");
  AST_OL_CLEAR: assert property (
    (load_display < OL_TRIP_PCT)[*3] |-> !overload_trip)
    else $error("trip held");
  AST_SLEEP_ZERO: assert property (sleep_shown |-> motor_zero_speed)
    else $error("asleep not zero");
  AST_WAKE_HYST: assert property (sleep_shown && run &&
    ({1'b0, commanded_speed} < {1'b0, idle_entry_level} + 17'(WAKE_MARGIN))
    |=> sleep_shown)
    else $error("early wake");
  AST_START_SLEEP: assert property ($rose(run) &&
    $past(commanded_speed) < $past(idle_entry_level) |=> sleep_shown)
    else $error("no sleep at start");
  // main scenarios reached
  COV_RUN: cover property ($rose(run));
  COV_SLEEP: cover property ($rose(sleep_shown));
  COV_TRIP: cover property ($rose(overload_trip));
  COV_REMOTE: cover property ($fell(is_local));
endmodule

bind drive_command_source_and_sleep_control drive_mode_monitor #(
  .CONFIRM_CYCLES(CONFIRM_CYCLES), .OL_CYCLES(OL_CYCLES)
) u_mon (
  .clk, .rst, .contacts_raw, .serial_stop, .cmd_source, .unit_class,
  .pid_enabled, .frequency_display_scale, .idle_entry_level,
  .output_frequency, .commanded_speed, .is_local, .run, .motor_zero_speed,
  .sleep_shown, .display_hertz, .speed_display, .load_display, .overload_trip
);

// file: testbench/contact_panel.sv
// keypad keys and terminal contacts worked by a test operator
module contact_panel
  import drive_mode_pkg::*;
(
  // clock
  input  wire logic clk,
  // contact levels toward the drive
  output contacts_t contacts_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // stop contact closed to common, every key up
  initial begin
    contacts_raw = '0;
    contacts_raw.terminal_stop_input = 1'b1;
  end
  // change the masked contacts just after an edge and hold them
  task automatic set_bits(input contacts_t mask, input contacts_t val);
    @(posedge clk);
    contacts_raw <= (contacts_raw & ~mask) | (val & mask);
  endtask
  // location key, then enter after a gap of whole cycles
  task automatic confirm_location(input int gap);
    set_bits(10'h100, 10'h100);
    repeat (gap) @(posedge clk);
    set_bits(10'h080, 10'h080);
  endtask
endmodule

// file: testbench/drive_command_source_and_sleep_control_test.sv
// self-checking bench for the drive mode block
module drive_command_source_and_sleep_control_test
  import drive_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // signals
  // ------
  localparam int DEB = 2620;
  localparam logic [3:0] S_RUN = 4'h0, S_LOC = 4'h1, S_AUTO = 4'h2,
    S_REF = 4'h3, S_SLP = 4'h4, S_ZERO = 4'h5, S_HZ = 4'h6,
    S_DISP = 4'h7, S_LOAD = 4'h8, S_OL = 4'h9;
  localparam contacts_t K_AM = 10'h200, K_LOC = 10'h180,
    K_START = 10'h040, K_STOP = 10'h020, K_TSTOP = 10'h010,
    K_TSTART = 10'h008, K_SA = 10'h004, K_SB = 10'h002;
  typedef struct packed { logic [3:0] sel; logic [31:0] val; } note_t;
  note_t notes[$];
  event chk_ev;
  int n_errors = 0;
  int tests_run = 0;
  logic clk = 1'b0, rst = 1'b1, serial_start = 1'b0, serial_stop = 1'b0;
  logic pid_enabled = 1'b0;
  contacts_t contacts_raw;
  speed_source_policy_t speed_source_policy = key_only_in_local;
  cmd_source_t cmd_source = cmd_local;
  select_cfg_t select_cfg = '0;
  unit_class_t unit_class = unit_hertz;
  logic [15:0] frequency_display_scale = 16'h0001;
  logic [15:0] load_display_scale = 16'h0064, drive_load = 16'h0000;
  logic [15:0] idle_entry_level = 16'h0096, idle_entry_delay = 16'h0000;
  logic [15:0] output_frequency = 16'h0000, commanded_speed = 16'h0258;
  logic is_local, auto_speed, run, motor_zero_speed, sleep_shown;
  logic display_hertz, overload_trip;
  speed_ref_t speed_ref;
  logic [31:0] speed_display;
  logic [15:0] load_display;
  // clock of 4 ns
  always #2 clk = ~clk;
  drive_command_source_and_sleep_control #(
    .CONFIRM_CYCLES(200), .OL_CYCLES(300)
  ) u_dut (
    .clk, .rst, .contacts_raw, .serial_start, .serial_stop,
    .speed_source_policy, .cmd_source, .select_cfg, .unit_class,
    .pid_enabled, .frequency_display_scale, .load_display_scale,
    .idle_entry_level, .idle_entry_delay, .output_frequency, .drive_load,
    .commanded_speed, .is_local, .auto_speed, .speed_ref, .run,
    .motor_zero_speed, .sleep_shown, .display_hertz, .speed_display,
    .load_display, .overload_trip
  );
  contact_panel u_panel (.clk, .contacts_raw);
  // ------
  // checking
  // ------
  function automatic logic [31:0] seen(input logic [3:0] s);
    case (s)
      S_RUN:   return 32'(run);
      S_LOC:   return 32'(is_local);
      S_AUTO:  return 32'(auto_speed);
      S_REF:   return 32'(speed_ref);
      S_SLP:   return 32'(sleep_shown);
      S_ZERO:  return 32'(motor_zero_speed);
      S_HZ:    return 32'(display_hertz);
      S_DISP:  return speed_display;
      S_LOAD:  return 32'(load_display);
      default: return 32'(overload_trip);
    endcase
  endfunction
  task automatic expect_out(input logic [3:0] s, input logic [31:0] v);
    notes.push_back({s, v});
    -> chk_ev;
  endtask
  // compare each note with its port
  always begin
    @(chk_ev);
    while (notes.size() > 0) begin
      note_t n;
      n = notes.pop_front();
      tests_run++;
      if (seen(n.sel) !== n.val) begin
        n_errors++;
        $display("[ERR] t=%0t sel %0h exp %0h got %0h", $time, n.sel,
                 n.val, seen(n.sel));
      end
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // contact change, then filter wait
  task automatic touch(input contacts_t m, input contacts_t v);
    u_panel.set_bits(m, v);
    settle(DEB);
  endtask
  task automatic serial_pulse(input logic stop);
    @(posedge clk);
    serial_start <= !stop;
    serial_stop <= stop;
    @(posedge clk);
    serial_start <= 1'b0;
    serial_stop <= 1'b0;
    settle(3);
  endtask
  // hang guard
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  // ------
  // scenarios
  // ------
  initial begin
    logic [15:0] f, s;
    void'($urandom(61));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    expect_out(S_RUN, 0);
    expect_out(S_LOC, 1);
    expect_out(S_ZERO, 1);
    for (int u = 0; u < 4; u++) begin
      f = 16'($urandom);
      s = 16'($urandom);
      @(posedge clk);
      unit_class <= unit_class_t'(u);
      output_frequency <= f;
      frequency_display_scale <= s;
      settle(2);
      expect_out(S_DISP, u == 1 ? 32'(f) * 32'(s) : 32'(f));
    end
    expect_out(S_HZ, 1);
    pid_enabled <= 1'b1;
    settle(2);
    expect_out(S_HZ, 1);
    load_display_scale <= 16'h0096;
    drive_load <= 16'h0064;
    settle(200);
    expect_out(S_LOAD, 32'h96);
    expect_out(S_OL, 0);
    settle(120);
    expect_out(S_OL, 1);
    drive_load <= 16'h005a;
    settle(4);
    expect_out(S_OL, 0);
    cmd_source <= cmd_remote;
    touch(K_START, K_START);
    expect_out(S_RUN, 0);
    touch(K_TSTART, K_TSTART);
    expect_out(S_RUN, 1);
    touch(K_STOP, K_STOP);
    expect_out(S_RUN, 0);
    touch(K_START | K_TSTART | K_STOP, '0);
    cmd_source <= cmd_local;
    touch(K_TSTART, K_TSTART);
    expect_out(S_RUN, 0);
    touch(K_START, K_START);
    expect_out(S_RUN, 1);
    touch(K_TSTOP, '0);
    expect_out(S_RUN, 0);
    touch(K_START | K_TSTART | K_TSTOP, K_TSTOP);
    cmd_source <= cmd_serial;
    serial_pulse(1'b0);
    expect_out(S_RUN, 1);
    expect_out(S_LOC, 0);
    commanded_speed <= 16'h0050;
    settle(3);
    expect_out(S_SLP, 1);
    expect_out(S_ZERO, 1);
    commanded_speed <= 16'h00a9;
    settle(3);
    expect_out(S_SLP, 1);
    commanded_speed <= 16'h00aa;
    settle(3);
    expect_out(S_SLP, 0);
    expect_out(S_ZERO, 0);
    idle_entry_delay <= 16'h0001;
    commanded_speed <= 16'h0050;
    serial_pulse(1'b1);
    expect_out(S_RUN, 0);
    serial_pulse(1'b0);
    expect_out(S_SLP, 1);
    serial_pulse(1'b1);
    expect_out(S_SLP, 0);
    commanded_speed <= 16'h0258;
    select_cfg <= '{location_select_function, fn_none, fn_none};
    cmd_source <= strip_selected_location;
    touch(K_SA, K_SA);
    expect_out(S_LOC, 1);
    touch(K_SA, '0);
    expect_out(S_LOC, 0);
    speed_source_policy <= policy_auto;
    select_cfg <= '{fn_none, fn_volt_ref, fn_none};
    touch(K_SB, K_SB);
    expect_out(S_REF, 32'(ref_volt));
    select_cfg <= '{fn_none, fn_preset, fn_none};
    settle(3);
    expect_out(S_REF, 32'(ref_preset));
    select_cfg <= '{fn_none, fn_none, fn_none};
    settle(3);
    expect_out(S_REF, 32'(ref_keypad));
    speed_source_policy <= key_only_in_local;
    cmd_source <= cmd_keypad;
    u_panel.confirm_location(260);
    touch('0, '0);
    expect_out(S_LOC, 0);
    touch(K_LOC, '0);
    u_panel.confirm_location(1);
    touch('0, '0);
    expect_out(S_LOC, 1);
    expect_out(S_AUTO, 0);
    touch(K_LOC | K_TSTOP | K_START, K_START);
    expect_out(S_RUN, 0);
    touch(K_START, '0);
    cmd_source <= cmd_keypad_nostop;
    touch(K_START, K_START);
    expect_out(S_RUN, 1);
    touch(K_START | K_STOP, K_STOP);
    expect_out(S_RUN, 0);
    touch(K_STOP | K_TSTOP | K_AM, K_TSTOP | K_AM);
    expect_out(S_AUTO, 1);
    speed_source_policy <= policy_manual;
    touch(K_AM, '0);
    touch(K_AM, K_AM);
    expect_out(S_AUTO, 1);
    speed_source_policy <= key_always_active;
    touch(K_AM, '0);
    touch(K_AM, K_AM);
    expect_out(S_AUTO, 0);
    cmd_source <= cmd_keypad;
    u_panel.confirm_location(1);
    touch('0, '0);
    expect_out(S_LOC, 0);
    expect_out(S_AUTO, 1);
    settle(2);
    tally_and_finish();
  end
endmodule
